// ---- shared/iexu_params.svh ----
// constants for the integer execution unit: sizes, timing, field positions
`ifndef IEXU_PARAMS_SVH
`define IEXU_PARAMS_SVH

`define IEXU_XLEN 64
`define IEXU_NREG 32
`define IEXU_WORD 32
`define IEXU_HALF_MSB 15
`define IEXU_P16_LAT 3
`define IEXU_P16_REP 2
`define IEXU_P32_LAT 4
`define IEXU_P32_REP 3
`define IEXU_PD_LAT 7
`define IEXU_PD_REP 6
`define IEXU_QW_LAT 36
`define IEXU_QD_LAT 68
`define IEXU_M3_STALL16 1
`define IEXU_M3_STALL32 2
`define IEXU_FP_STAGES 7
`define IEXU_INT_STAGES 5

`endif

// ---- shared/iexu_pkg.sv ----
// types shared by the integer execution unit and its multiply/divide unit
`include "iexu_params.svh"

package iexu_pkg;

    typedef enum logic [4:0] {
        op_nop, op_add, op_sub, op_addi, op_and, op_or, op_xor, op_nor,
        op_move, op_sll, op_srl, op_sra, op_ld, op_lw, op_sd, op_sw,
        op_fld, op_fsd, op_beq, op_bne, op_md, op_mul3, op_move_from_upper_result, op_move_from_bottom_result
    } iexu_op_t;

    typedef enum logic [3:0] {
        md_mult, md_multu, md_mad, md_madu, md_dmult, md_dmultu,
        md_div, md_divu, md_doubleword_quotient_op, md_ddivu
    } iexu_md_t;

    typedef struct packed {
        logic valid;
        logic fp;
        iexu_op_t op;
        iexu_md_t md;
        logic [4:0] rs;
        logic [4:0] rt;
        logic [4:0] rd;
        logic [15:0] imm;
        logic [`IEXU_XLEN-1:0] pc;
    } iexu_instr_t;

    typedef struct packed {
        logic re;
        logic we;
        logic fpu;
        logic [7:0] be;
        logic [`IEXU_XLEN-1:0] addr;
        logic [`IEXU_XLEN-1:0] wdata;
    } iexu_dmem_t;

endpackage

// ---- logic/iexu_mdu.sv ----
// autonomous multiply/divide unit with upper and bottom result registers
`timescale 1ns/100ps
`include "iexu_params.svh"

module iexu_mdu (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input iexu_pkg::iexu_md_t md,
    input wire logic [63:0] a,
    input wire logic [63:0] b,
    output logic ready,
    output logic done,
    output logic [63:0] hi,
    output logic [63:0] lo
);
    import iexu_pkg::*;

    localparam logic [6:0] P16_LAT = 7'(`IEXU_P16_LAT);
    localparam logic [6:0] P16_REP = 7'(`IEXU_P16_REP);
    localparam logic [6:0] P32_LAT = 7'(`IEXU_P32_LAT);
    localparam logic [6:0] P32_REP = 7'(`IEXU_P32_REP);
    localparam logic [6:0] PD_LAT = 7'(`IEXU_PD_LAT);
    localparam logic [6:0] PD_REP = 7'(`IEXU_PD_REP);
    localparam logic [6:0] QW_LAT = 7'(`IEXU_QW_LAT);
    localparam logic [6:0] QD_LAT = 7'(`IEXU_QD_LAT);

    logic [6:0] lat_q, rep_q, lat_sel, rep_sel;
    logic [63:0] hi_q, lo_q, hi_d, lo_d;

    // ------------------------------------------------------------
    // operand size and sign
    // ------------------------------------------------------------
    wire sgn = (md == md_mult) | (md == md_mad) | (md == md_dmult) |
               (md == md_div) | (md == md_doubleword_quotient_op);
    wire a16 = sgn ? (&a[31:15] | ~|a[31:15]) : ~|a[31:16];
    wire b16 = sgn ? (&b[31:15] | ~|b[31:15]) : ~|b[31:16];
    wire both16 = a16 & b16;

    wire signed [32:0] xa = {sgn & a[31], a[31:0]};
    wire signed [32:0] xb = {sgn & b[31], b[31:0]};
    wire signed [64:0] ya = {sgn & a[63], a};
    wire signed [64:0] yb = {sgn & b[63], b};
    wire signed [65:0] pw = xa * xb;
    wire signed [129:0] pd = ya * yb;
    wire [63:0] acc = {hi_q[31:0], lo_q[31:0]} + pw[63:0];
    wire bw0 = ~|b[31:0];
    wire bd0 = ~|b;
    // the all-ones fill must be signed, or the divide turns unsigned
    wire signed [32:0] qw = bw0 ? 33'sh1FFFFFFFF : xa / xb;
    wire signed [32:0] rw = bw0 ? xa : xa % xb;
    wire signed [64:0] qd = bd0 ? 65'sh1FFFFFFFFFFFFFFFF : ya / yb;
    wire signed [64:0] rd = bd0 ? ya : ya % yb;

    // ------------------------------------------------------------
    // timing class and result select
    // ------------------------------------------------------------
    always_comb begin
        lat_sel = both16 ? P16_LAT : P32_LAT;
        rep_sel = both16 ? P16_REP : P32_REP;
        hi_d = {{32{pw[63]}}, pw[63:32]};
        lo_d = {{32{pw[31]}}, pw[31:0]};
        case (md)
            md_mult, md_multu: begin
            end
            md_mad, md_madu: begin
                hi_d = {{32{acc[63]}}, acc[63:32]};
                lo_d = {{32{acc[31]}}, acc[31:0]};
            end
            md_dmult, md_dmultu: begin
                lat_sel = PD_LAT;
                rep_sel = PD_REP;
                hi_d = pd[127:64];
                lo_d = pd[63:0];
            end
            md_div, md_divu: begin
                lat_sel = QW_LAT;
                rep_sel = QW_LAT;
                hi_d = {{32{rw[31]}}, rw[31:0]};
                lo_d = {{32{qw[31]}}, qw[31:0]};
            end
            md_doubleword_quotient_op, md_ddivu: begin
                lat_sel = QD_LAT;
                rep_sel = QD_LAT;
                hi_d = rd[63:0];
                lo_d = qd[63:0];
            end
            default: begin
            end
        endcase
    end

    // results land at start; the done interlock hides them until the
    // latency has run, which keeps overlapped accumulates consistent
    always_ff @(posedge clk) begin
        if (srst) begin
            lat_q <= 7'h00;
            rep_q <= 7'h00;
            hi_q <= 64'h0;
            lo_q <= 64'h0;
        end else if (start) begin
            lat_q <= lat_sel - 7'h01;
            rep_q <= rep_sel - 7'h01;
            hi_q <= hi_d;
            lo_q <= lo_d;
        end else begin
            lat_q <= (lat_q == 7'h00) ? 7'h00 : lat_q - 7'h01;
            rep_q <= (rep_q == 7'h00) ? 7'h00 : rep_q - 7'h01;
        end
    end

    assign ready = (rep_q == 7'h00);
    assign done = (lat_q == 7'h00);
    assign hi = hi_q;
    assign lo = lo_q;

endmodule // iexu_mdu

// ---- logic/iexu_top.sv ----
// integer execution unit: dual dispatch, register file, alu, pipeline
`timescale 1ns/100ps
`include "iexu_params.svh"

module iexu_top #(
    parameter int NREG = `IEXU_NREG
) (
    input wire logic clk,
    input wire logic srst,
    input iexu_pkg::iexu_instr_t slot_a,
    input iexu_pkg::iexu_instr_t slot_b,
    output logic take_a,
    output logic take_b,
    output logic stall,
    output iexu_pkg::iexu_instr_t fp_issue_q,
    output logic fp_busy,
    output iexu_pkg::iexu_dmem_t dmem_q,
    input wire logic [63:0] dmem_rdata,
    output logic branch_taken_q,
    output logic [63:0] branch_target_q,
    output logic retire_valid_q,
    output logic [63:0] retire_pc_q
);
    import iexu_pkg::*;

    generate
        if (NREG != 32) begin : g_bad_nreg
            $error("iexu_top: register fields are 5 bits, NREG must be 32");
        end
    endgenerate

    localparam logic [1:0] M3_S16 = 2'(`IEXU_M3_STALL16);
    localparam logic [1:0] M3_S32 = 2'(`IEXU_M3_STALL32);

    // ------------------------------------------------------------
    // dispatch
    // ------------------------------------------------------------
    iexu_instr_t int_pick, fp_pick;
    wire a_int = slot_a.valid & ~slot_a.fp;
    wire b_int = slot_b.valid & ~slot_b.fp;
    // asymmetric slots: an integer op pairs only with an fp op
    wire pair_ok = slot_a.valid & slot_b.valid &
                   (slot_a.fp != slot_b.fp);
    assign take_a = ~stall & slot_a.valid;
    assign take_b = ~stall & pair_ok;
    assign int_pick = a_int ? slot_a : slot_b;
    assign fp_pick = slot_a.fp ? slot_a : slot_b;
    wire int_go = ~stall & (a_int | (pair_ok & b_int));
    wire fp_go = ~stall & slot_a.valid & (slot_a.fp | pair_ok);

    // ------------------------------------------------------------
    // pipeline state
    // ------------------------------------------------------------
    logic [63:0] gpr [NREG];
    iexu_instr_t id_q, ex_q;
    logic [63:0] ex_a_q, ex_b_q, ex_tgt_q;
    logic mem_v_q, mem_wen_q, mem_ld_q, mem_lw_q, mem_hiw_q;
    logic [4:0] mem_rd_q, wb_rd_q;
    logic [63:0] mem_val_q, mem_pc_q, wb_val_q;
    logic wb_wen_q;
    logic [1:0] m3_cnt_q;
    logic [`IEXU_FP_STAGES-1:0] fp_pipe_q;
    logic [63:0] ex_res, opa, opb;
    logic mdu_ready, mdu_done;
    logic [63:0] md_hi, md_lo;

    // ------------------------------------------------------------
    // execute stage decode
    // ------------------------------------------------------------
    wire ex_v = ex_q.valid;
    wire ex_is_ld = (ex_q.op == op_ld) | (ex_q.op == op_lw) |
                    (ex_q.op == op_fld);
    wire ex_is_st = (ex_q.op == op_sd) | (ex_q.op == op_sw) |
                    (ex_q.op == op_fsd);
    wire ex_fpmem = (ex_q.op == op_fld) | (ex_q.op == op_fsd);
    wire ex_br = (ex_q.op == op_beq) | (ex_q.op == op_bne);
    wire ex_md = ex_q.op == op_md;
    wire ex_m3 = ex_q.op == op_mul3;
    wire ex_mv = (ex_q.op == op_move_from_upper_result) | (ex_q.op == op_move_from_bottom_result);
    // fp loads target the fp file, so they never write a gpr
    wire ex_wen = ex_v & (ex_q.rd != 5'h00) & ~ex_is_st & ~ex_br &
                  ~ex_md & (ex_q.op != op_nop) & (ex_q.op != op_fld);

    // ------------------------------------------------------------
    // hazards
    // ------------------------------------------------------------
    wire m3_small = (&ex_a_q[31:15] | ~|ex_a_q[31:15]) &
                    (&ex_b_q[31:15] | ~|ex_b_q[31:15]);
    wire [1:0] m3_need = m3_small ? M3_S16 : M3_S32;
    wire h_md = ex_md & ~mdu_ready;
    wire h_mv = ex_mv & ~mdu_done;
    wire h_m3 = ex_m3 & (m3_cnt_q != m3_need);
    wire ex_hold = ex_v & (h_md | h_mv | h_m3);
    // a load's data exists only in the cache stage, so a direct
    // consumer waits one cycle before it can take the bypass
    wire ld_use = id_q.valid & ex_v & ex_is_ld & ex_wen &
                  ((ex_q.rd == id_q.rs) | (ex_q.rd == id_q.rt));
    assign stall = ex_hold | ld_use;
    wire md_start = ex_v & ex_md & mdu_ready;

    // ------------------------------------------------------------
    // register read with bypass
    // ------------------------------------------------------------
    wire [63:0] mem_res;

    function automatic logic [63:0] rd_fwd(input logic [4:0] r);
        logic [63:0] v;
        v = gpr[r];
        if (wb_wen_q && wb_rd_q == r) v = wb_val_q;
        if (mem_v_q && mem_wen_q && mem_rd_q == r) v = mem_res;
        if (ex_wen && ex_q.rd == r) v = ex_res;
        if (r == 5'h00) v = 64'h0;
        return v;
    endfunction

    logic [63:0] id_a, id_b;
    // a process, since it also wakes on the state the function reads
    always_comb begin
        id_a = rd_fwd(id_q.rs);
        id_b = rd_fwd(id_q.rt);
    end
    wire [63:0] id_tgt = id_q.pc + 64'h4 +
                         {{46{id_q.imm[15]}}, id_q.imm, 2'b00};

    // ------------------------------------------------------------
    // alu: adder, logic unit, shifter
    // ------------------------------------------------------------
    wire [63:0] imm_sx = {{48{ex_q.imm[15]}}, ex_q.imm};
    wire use_imm = (ex_q.op == op_addi) | ex_is_ld | ex_is_st;
    assign opa = ex_a_q;
    assign opb = use_imm ? imm_sx : ex_b_q;
    wire [63:0] sum = (ex_q.op == op_sub) ? opa - opb : opa + opb;
    wire [5:0] sh = ex_q.imm[5:0];
    wire signed [63:0] m3_p = $signed(opa[31:0]) * $signed(opb[31:0]);
    // store data alignment has its own shift by sum[2], apart from the alu shifter
    wire [63:0] st_data = (ex_q.op == op_sw) ?
                          (ex_b_q << {sum[2], 5'b00000}) : ex_b_q;
    wire [7:0] st_be = (ex_q.op != op_sw) ? 8'hFF :
                       (sum[2] ? 8'hF0 : 8'h0F);
    wire br_eq = opa == ex_b_q;
    wire br_take = ex_br & ((ex_q.op == op_beq) == br_eq);

    always_comb begin
        case (ex_q.op)
            op_add, op_sub, op_addi: ex_res = sum;
            op_and: ex_res = opa & opb;
            op_or: ex_res = opa | opb;
            op_xor: ex_res = opa ^ opb;
            op_nor: ex_res = ~(opa | opb);
            op_move: ex_res = opa | 64'h0;
            op_sll: ex_res = ex_b_q << sh;
            op_srl: ex_res = ex_b_q >> sh;
            op_sra: ex_res = $signed(ex_b_q) >>> sh;
            op_mul3: ex_res = {{32{m3_p[31]}}, m3_p[31:0]};
            op_move_from_upper_result: ex_res = md_hi;
            op_move_from_bottom_result: ex_res = md_lo;
            default: ex_res = sum;
        endcase
    end

    iexu_mdu u_mdu (
        .clk(clk),
        .srst(srst),
        .start(md_start),
        .md(ex_q.md),
        .a(ex_a_q),
        .b(ex_b_q),
        .ready(mdu_ready),
        .done(mdu_done),
        .hi(md_hi),
        .lo(md_lo)
    );

    // ------------------------------------------------------------
    // cache stage load alignment
    // ------------------------------------------------------------
    wire [31:0] ld_word = mem_hiw_q ? dmem_rdata[63:32] : dmem_rdata[31:0];
    assign mem_res = !mem_ld_q ? mem_val_q :
                     (mem_lw_q ? {{32{ld_word[31]}}, ld_word} :
                      dmem_rdata);

    // ------------------------------------------------------------
    // decode/read and execute registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            id_q <= '0;
        end else if (!stall) begin
            id_q <= int_go ? int_pick : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ex_q <= '0;
            ex_a_q <= 64'h0;
            ex_b_q <= 64'h0;
            ex_tgt_q <= 64'h0;
        end else if (ld_use && !ex_hold) begin
            ex_q <= '0;
        end else if (!ex_hold) begin
            ex_q <= id_q;
            ex_a_q <= id_a;
            ex_b_q <= id_b;
            ex_tgt_q <= id_tgt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !ex_v || !ex_m3 || !h_m3) begin
            m3_cnt_q <= 2'b00;
        end else begin
            m3_cnt_q <= m3_cnt_q + 2'b01;
        end
    end

    // ------------------------------------------------------------
    // cache stage and write back
    // ------------------------------------------------------------
    wire ex_go = ex_v & ~ex_hold;

    always_ff @(posedge clk) begin
        if (srst) begin
            mem_v_q <= 1'b0;
            mem_wen_q <= 1'b0;
            mem_ld_q <= 1'b0;
            mem_lw_q <= 1'b0;
            mem_hiw_q <= 1'b0;
            mem_rd_q <= 5'h00;
            mem_val_q <= 64'h0;
            mem_pc_q <= 64'h0;
            dmem_q <= '0;
        end else begin
            mem_v_q <= ex_go;
            mem_wen_q <= ex_go & ex_wen;
            mem_ld_q <= ex_is_ld;
            mem_lw_q <= ex_q.op == op_lw;
            mem_hiw_q <= sum[2];
            mem_rd_q <= ex_q.rd;
            mem_val_q <= ex_res;
            mem_pc_q <= ex_q.pc;
            // virtual address goes out with the request; translation
            // runs beside the cache lookup
            dmem_q.re <= ex_go & ex_is_ld;
            dmem_q.we <= ex_go & ex_is_st;
            dmem_q.fpu <= ex_fpmem;
            dmem_q.be <= st_be;
            dmem_q.addr <= sum;
            dmem_q.wdata <= st_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wb_wen_q <= 1'b0;
            wb_rd_q <= 5'h00;
            wb_val_q <= 64'h0;
            retire_valid_q <= 1'b0;
            retire_pc_q <= 64'h0;
        end else begin
            wb_wen_q <= mem_v_q & mem_wen_q;
            wb_rd_q <= mem_rd_q;
            wb_val_q <= mem_res;
            retire_valid_q <= mem_v_q;
            retire_pc_q <= mem_pc_q;
        end
    end

    // register zero is never written or reset; the read path forces it to zero
    always_ff @(posedge clk) begin
        if (wb_wen_q && wb_rd_q != 5'h00) begin
            gpr[wb_rd_q] <= wb_val_q;
        end
    end

    // ------------------------------------------------------------
    // branch result and fp issue
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            branch_taken_q <= 1'b0;
            branch_target_q <= 64'h0;
            fp_issue_q <= '0;
            fp_pipe_q <= '0;
        end else begin
            branch_taken_q <= ex_go & br_take;
            branch_target_q <= ex_tgt_q;
            fp_issue_q <= fp_go ? fp_pick : '0;
            fp_pipe_q <= {fp_pipe_q[`IEXU_FP_STAGES-2:0], fp_go};
        end
    end

    assign fp_busy = |fp_pipe_q;

endmodule // iexu_top

// ---- dv/iexu_chk.sv ----
// port-level assertions for the integer execution unit
`timescale 1ns/100ps
module iexu_chk (
    input wire logic clk,
    input wire logic srst,
    input iexu_pkg::iexu_instr_t slot_a,
    input iexu_pkg::iexu_instr_t slot_b,
    input wire logic take_a,
    input wire logic take_b,
    input wire logic stall,
    input iexu_pkg::iexu_instr_t fp_issue_q,
    input wire logic fp_busy,
    input iexu_pkg::iexu_dmem_t dmem_q,
    input wire logic branch_taken_q,
    input wire logic retire_valid_q
);
    import iexu_pkg::*;
    logic [3:0] since_q;
    logic [3:0] since_d;
    logic fp_take;
    // saturating count of cycles since the last fp issue
    assign since_d = fp_issue_q.valid ? 4'h0 :
        (since_q == 4'hF) ? since_q : since_q + 4'h1;
    assign fp_take = (take_a && slot_a.valid && slot_a.fp) ||
        (take_b && slot_b.valid && slot_b.fp);
    always_ff @(posedge clk) begin
        if (srst) since_q <= 4'hF;
        else since_q <= since_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_pair_mixed: assert property (take_a && take_b |->
        slot_a.fp != slot_b.fp) else $error("same class paired");
    a_b_needs_a: assert property (take_b |-> take_a)
        else $error("second slot taken alone");
    a_stall_holds: assert property (stall |-> !take_a && !take_b)
        else $error("slot taken during stall");
    a_fp_follows: assert property (take_b && slot_b.valid && slot_b.fp
        |=> fp_issue_q.valid && fp_issue_q.pc == $past(slot_b.pc))
        else $error("fp op not forwarded");
    a_fp_cause: assert property (fp_issue_q.valid |-> $past(fp_take))
        else $error("fp issue without take");
    a_fp_busy_hold: assert property (fp_issue_q.valid |=> fp_busy[*5])
        else $error("fp busy dropped early");
    a_fp_busy_end: assert property (fp_busy |->
        fp_issue_q.valid || since_q <= 4'h8) else $error("fp busy too long");
    a_dmem_excl: assert property (!(dmem_q.re && dmem_q.we))
        else $error("read and write together");
    a_reset_quiet: assert property (disable iff (1'b0) srst |=>
        !retire_valid_q && !dmem_q.we && !dmem_q.re && !branch_taken_q &&
        !fp_issue_q.valid) else $error("output active after reset");
    // the first reset edge still sees an unreset pipeline, so start later
    a_reset_free: assert property (disable iff (1'b0)
        srst ##1 srst |-> !stall && take_a == slot_a.valid)
        else $error("stall in reset");
endmodule // iexu_chk

bind iexu_top iexu_chk chk_u (.clk(clk), .srst(srst), .slot_a(slot_a),
    .slot_b(slot_b), .take_a(take_a), .take_b(take_b), .stall(stall),
    .fp_issue_q(fp_issue_q), .fp_busy(fp_busy), .dmem_q(dmem_q),
    .branch_taken_q(branch_taken_q), .retire_valid_q(retire_valid_q));

// ---- dv/testbench.sv ----
// self-checking bench for the integer execution unit
`timescale 1ns/100ps
module testbench;
    import iexu_pkg::*;
    logic clk, srst, take_a, take_b, stall, fp_busy, branch_taken_q;
    logic retire_valid_q;
    iexu_instr_t slot_a, slot_b, fp_issue_q;
    iexu_dmem_t dmem_q;
    logic [63:0] dmem_rdata, branch_target_q, retire_pc_q, pc, hi, lo;
    logic [63:0] rf [32];
    logic [63:0] exp_q [$];
    logic [63:0] got_q [$];
    logic [63:0] rexp_q [$], rgot_q [$];
    int fails, cmp_count;
    iexu_op_t alu_ops [15] = '{op_addi, op_add, op_sub, op_and, op_or,
        op_xor, op_nor, op_sll, op_srl, op_sra, op_ld, op_beq, op_bne,
        op_move, op_lw};
    iexu_top dut_u (.clk(clk), .srst(srst), .slot_a(slot_a),
        .slot_b(slot_b), .take_a(take_a), .take_b(take_b), .stall(stall),
        .fp_issue_q(fp_issue_q), .fp_busy(fp_busy), .dmem_q(dmem_q),
        .dmem_rdata(dmem_rdata), .branch_taken_q(branch_taken_q),
        .branch_target_q(branch_target_q), .retire_valid_q(retire_valid_q),
        .retire_pc_q(retire_pc_q));
    // memory answers from the address alone, so loads are predictable
    assign dmem_rdata = {dmem_q.addr[31:0], ~dmem_q.addr[31:0]};
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // stores, taken branches and retirements leave in program order
    always @(posedge clk) begin
        if (dmem_q.we === 1'b1) got_q.push_back(dmem_q.wdata);
        if (branch_taken_q === 1'b1) got_q.push_back(branch_target_q);
        if (retire_valid_q === 1'b1) rgot_q.push_back(retire_pc_q);
    end
    // ----------------------------------------
    // expectation functions
    // ----------------------------------------
    function automatic logic [63:0] sx(input logic [31:0] v);
        return {{32{v[31]}}, v};
    endfunction
    function automatic logic [63:0] s16(input logic [15:0] v);
        return {{48{v[15]}}, v};
    endfunction
    function automatic logic [63:0] alu(input iexu_op_t op,
            input logic [63:0] a, input logic [63:0] b, input logic [15:0] im);
        logic [63:0] ad;
        ad = a + s16(im);
        case (op)
            op_addi: return ad;
            op_add: return a + b;
            op_sub: return a - b;
            op_and: return a & b;
            op_or: return a | b;
            op_xor: return a ^ b;
            op_nor: return ~(a | b);
            op_sll: return b << im[5:0];
            op_srl: return b >> im[5:0];
            op_sra: return $signed(b) >>> im[5:0];
            op_ld: return {ad[31:0], ~ad[31:0]};
            op_lw: return sx(ad[2] ? ad[31:0] : ~ad[31:0]);
            op_move: return a;
            default: return sx(a[31:0] * b[31:0]);
        endcase
    endfunction
    function automatic logic [127:0] mdx(input iexu_md_t k,
            input logic [63:0] a, input logic [63:0] b, input logic [63:0] h,
            input logic [63:0] l);
        logic signed [127:0] p;
        logic [63:0] acc;
        p = '0;
        if (k == md_mult || k == md_mad) p = $signed(a[31:0]) * $signed(b[31:0]);
        if (k == md_multu || k == md_madu) p = a[31:0] * b[31:0];
        if (k == md_dmult) p = $signed(a) * $signed(b);
        if (k == md_dmultu) p = a * b;
        acc = {h[31:0], l[31:0]} + p[63:0];
        case (k)
            md_mult, md_multu: return {sx(p[63:32]), sx(p[31:0])};
            md_mad, md_madu: return {sx(acc[63:32]), sx(acc[31:0])};
            md_dmult, md_dmultu: return p;
            md_div: return (b[31:0] == 32'h0) ? {sx(a[31:0]), ~64'h0} :
                {sx($signed(a[31:0]) % $signed(b[31:0])),
                sx($signed(a[31:0]) / $signed(b[31:0]))};
            md_divu: return (b[31:0] == 32'h0) ? {sx(a[31:0]), ~64'h0} :
                {sx(a[31:0] % b[31:0]), sx(a[31:0] / b[31:0])};
            md_doubleword_quotient_op: return (b == 64'h0) ? {a, ~64'h0} :
                {64'($signed(a) % $signed(b)), 64'($signed(a) / $signed(b))};
            default: return (b == 64'h0) ? {a, ~64'h0} : {a % b, a / b};
        endcase
    endfunction
    // ----------------------------------------
    // driver and compare tasks
    // ----------------------------------------
    task automatic cmp(input string what, input logic [63:0] e,
            input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // mode 0: slot_a alone, 1: fp op beside it, 2: second int op offered
    task automatic issue(input iexu_instr_t a, input int mode);
        iexu_instr_t b;
        int n;
        b = a;
        b.fp = (mode == 1);
        b.valid = (mode != 0);
        b.pc = a.pc + 64'h4;
        slot_a <= a;
        slot_b <= b;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (take_a !== 1'b1 && n < 400);
        if (n >= 400) begin
            fails++;
            complete_run();
        end
        cmp("take_b", 64'(mode == 1), 64'(take_b));
        @(posedge clk);
    endtask
    task automatic run(input iexu_op_t op, input iexu_md_t k,
            input logic [4:0] rs, input logic [4:0] rt, input logic [4:0] rd,
            input logic [15:0] im, input int mode);
        iexu_instr_t i;
        logic [127:0] r;
        i = '0;
        i.valid = 1'b1;
        i.op = op;
        i.md = k;
        i.rs = rs;
        i.rt = rt;
        i.rd = rd;
        i.imm = im;
        i.pc = pc;
        pc = pc + 64'h8;
        rexp_q.push_back(i.pc);
        case (op)
            op_md: begin
                r = mdx(k, rf[rs], rf[rt], hi, lo);
                hi = r[127:64];
                lo = r[63:0];
            end
            op_move_from_upper_result: rf[rd] = hi;
            op_move_from_bottom_result: rf[rd] = lo;
            op_sd: exp_q.push_back(rf[rt]);
            op_beq: if (rf[rs] == rf[rt]) exp_q.push_back(i.pc + 4 + (s16(im) << 2));
            op_bne: if (rf[rs] != rf[rt]) exp_q.push_back(i.pc + 4 + (s16(im) << 2));
            default: rf[rd] = alu(op, rf[rs], rf[rt], im);
        endcase
        rf[0] = '0;
        issue(i, mode);
    endtask
    task automatic drain(input string what);
        slot_a <= '0;
        slot_b <= '0;
        repeat (20) @(posedge clk);
        cmp({what, " count"}, 64'(exp_q.size()), 64'(got_q.size()));
        while (exp_q.size() > 0 && got_q.size() > 0)
            cmp(what, exp_q.pop_front(), got_q.pop_front());
        cmp({what, " retired"}, 64'(rexp_q.size()),
            64'(rgot_q.size()));
        while (rexp_q.size() > 0 && rgot_q.size() > 0)
            cmp("retire pc", rexp_q.pop_front(), rgot_q.pop_front());
        exp_q.delete();
        got_q.delete();
        rexp_q.delete();
        rgot_q.delete();
        $display("test %s done", what);
    endtask
    initial begin
        iexu_op_t op;
        logic [4:0] rs, rt, rd;
        logic [15:0] im;
        srst = 1'b1;
        slot_a = '0;
        slot_b = '0;
        fails = 0;
        cmp_count = 0;
        pc = 64'h1000;
        hi = '0;
        lo = '0;
        void'($urandom(48455));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (int r = 0; r < 8; r++) run(op_addi, md_mult, 5'h0, 5'h0, 5'(r),
            16'($urandom), r % 3);
        for (int r = 0; r < 8; r++) run(op_sd, md_mult, 5'h0, 5'(r), 5'h0,
            16'h0, 0);
        drain("setup");
        repeat (80) begin
            op = alu_ops[$urandom % 15];
            rs = (op == op_ld || op == op_lw) ? 5'h0 : 5'($urandom % 8);
            rt = 5'($urandom % 8);
            rd = 5'($urandom % 8);
            im = 16'($urandom);
            if (op == op_ld) im[2:0] = 3'h0;
            if (op == op_lw) im[1:0] = 2'h0;
            run(op, md_mult, rs, rt, rd, im, $urandom % 3);
            run(op_sd, md_mult, 5'h0, rd, 5'h0, 16'h0, 0);
        end
        drain("alu");
        run(op_move_from_upper_result, md_mult, 5'h0, 5'h0, 5'h3, 16'h0, 0);
        run(op_sd, md_mult, 5'h0, 5'h3, 5'h0, 16'h0, 0);
        for (int n = 0; n < 20; n++) begin
            run(op_addi, md_mult, 5'h0, 5'h0, 5'h1, 16'($urandom), 0);
            im = ($urandom % 4 == 0) ? 16'h0 : 16'($urandom);
            run(op_addi, md_mult, 5'h0, 5'h0, 5'h2, im, 0);
            run(op_sll, md_mult, 5'h0, 5'h1, 5'h1, 16'($urandom % 40), 0);
            run(op_md, iexu_md_t'(n % 10), 5'h1, 5'h2, 5'h0, 16'h0,
                n % 2);
            // the upper and bottom reads after this also show the pair was left alone
            run(op_mul3, md_mult, 5'h1, 5'h2, 5'h5, 16'h0, 0);
            run(op_move_from_upper_result, md_mult, 5'h0, 5'h0, 5'h3, 16'h0, 0);
            run(op_move_from_bottom_result, md_mult, 5'h0, 5'h0, 5'h4, 16'h0, 0);
            for (int r = 3; r < 6; r++) run(op_sd, md_mult, 5'h0, 5'(r),
                5'h0, 16'h0, 0);
        end
        drain("muldiv");
        complete_run();
    end
endmodule // testbench
